/* rtl/isf_pkg.sv */
// Constants and carrier types of the two-wire bus status flag block
`default_nettype none
package isf_pkg;
  // Register byte offsets on the AXI4-Lite bus
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OWN = 8'h08;
  // Field positions in bus_status_flags
  localparam int BIT_BUSY = 7;
  localparam int BIT_IRQ = 6;
  localparam int BIT_GUARD = 5;
  localparam int BIT_RSVD = 4;
  localparam int BIT_ARB = 3;
  localparam int BIT_AAS = 2;
  localparam int BIT_GC = 1;
  localparam int BIT_ACK = 0;
  // Field positions in the mode register
  localparam int MODE_MST = 0;
  localparam int MODE_TX = 1;
  localparam int MODE_FS = 2;
  localparam int MODE_SER = 3;
  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h30;
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [6:0] OWN_RST = 7'h00;
  // General call address byte
  localparam logic [7:0] GC_VALUE = 8'h00;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Events and levels coming from the shift engine
  typedef struct packed {
    logic xfer_end;
    logic addr_valid;
    logic [7:0] addr_byte;
    logic ack_valid;
    logic ack_bit;
    logic data_wr;
    logic data_rd;
    logic drv_sda;
    logic drv_scl;
  } isf_eng_t;

  // Control handed back to the shift engine
  typedef struct packed {
    logic master;
    logic tx;
    logic fs;
    logic serial;
    logic start_req;
    logic stop_req;
    logic ack_drive;
    logic busy;
  } isf_ctl_t;
endpackage
`default_nettype wire

/* rtl/isf_status_flags.sv */
// Status flags, condition control and AXI4-Lite registers of the bus block
// Summary of operation
// - Interrupt flag clears only by reading it as 1 then writing 0.
// - Master mode sets interrupt flag at transfer end and arbitration loss.
// - Addressed slave sets interrupt flag on match, then each transfer end.
// - Non-addressing slave sets interrupt flag at every transfer end.
// - Master write busy=1, guard=0 issues start or repeated start.
// - Master write busy=0, guard=0 issues a stop condition.
// - Guard bit always reads 1 and is never stored.
// - Reserved status bit 4 always reads 1, cannot be changed.
// - Master transmit: data mismatch at clock rise sets arbitration lost.
// - Master transmit: own clock high at bus clock fall loses arbitration.
// - Arbitration loss sets interrupt flag in the same event.
// - Arbitration lost clears by reading 1 then writing 0.
// - Data write in transmit or read in receive clears arbitration lost.
// - Addressed slave receive sets address flag on own or general call.
// - Address flag clears by read-1/write-0 or data register access.
// - Addressed slave receive sets general call flag on zero byte.
// - General call flag clears by read-1/write-0 or data access.
// - Transmit with acknowledge framing captures receiver acknowledge bit.
// - Receive mode drives software acknowledge value after each byte.
// - Acknowledge read gives captured bit if transmit, else software.
// - Data fall with clock high sets busy; data rise clears it.
// - Status resets to 30h on reset and hardware standby.
// - Arbitration loss clears master and transmit selects.
// - Busy bit cannot be written in slave mode.
`default_nettype none
module isf_status_flags (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic standby_i,
  // Bus pins, asynchronous to clk_i
  input wire logic scl_i,
  input wire logic sda_i,
  // Shift engine side
  input wire isf_pkg::isf_eng_t eng_i,
  output isf_pkg::isf_ctl_t ctl_o,
  // AXI4-Lite slave
  input wire logic [isf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [isf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import isf_pkg::*;

  // Sync reset plus standby both return the flags to their reset state
  // reset or standby
  logic init;
  assign init = !resetn_i || standby_i;

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [2:0] scl_s_q;
  logic [2:0] sda_s_q;
  logic scl_f_q;
  logic sda_f_q;

  // Three stages; the filtered level moves only when stages 1 and 2 agree
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
    end
    else if (ce_i)
    begin
      scl_s_q <= {scl_s_q[1:0], scl_i};
      sda_s_q <= {sda_s_q[1:0], sda_i};
    end
  end

  // Filtered levels; stage 0 is seen by stage 1 only
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end
    else if (ce_i)
    begin
      if (scl_s_q[1] == scl_s_q[2])
        scl_f_q <= scl_s_q[2];
      if (sda_s_q[1] == sda_s_q[2])
        sda_f_q <= sda_s_q[2];
    end
  end

  // Edge and condition detection on the filtered levels
  logic scl_new;
  logic sda_new;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  assign scl_new = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
  assign sda_new = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
  assign scl_rise = ce_i && !scl_f_q && scl_new;
  assign scl_fall = ce_i && scl_f_q && !scl_new;
  // Clock must be high before and after so a clock edge is no condition
  assign start_seen = ce_i && scl_f_q && scl_new && sda_f_q && !sda_new;
  assign stop_seen = ce_i && scl_f_q && scl_new && !sda_f_q && sda_new;

  // ****************************************************
  // AXI4-Lite slave
  // ****************************************************
  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic wr_go;
  logic rd_go;
  logic wr_stat;
  logic rd_stat;

  // Readies drop while frozen, else a beat would be taken and then lost
  assign s_axi_awready = ce_i && !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = ce_i && !w_full_q && !s_axi_bvalid;
  assign s_axi_arready = ce_i && !s_axi_rvalid;
  assign wr_go = ce_i && aw_full_q && w_full_q && !s_axi_bvalid;
  assign rd_go = ce_i && s_axi_arvalid && s_axi_arready;
  assign wr_stat = wr_go && w_lane_q && (aw_addr_q == OFS_STATUS);
  assign rd_stat = rd_go && (s_axi_araddr == OFS_STATUS);

  // Address and data are taken in either order and held until paired
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_full_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      else if (wr_go)
        w_full_q <= 1'b0;
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_q == OFS_STATUS || aw_addr_q == OFS_MODE
                        || aw_addr_q == OFS_OWN) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************
  // Mode and own address registers
  // ****************************************************
  logic [3:0] mode_q;
  logic [6:0] own_q;
  logic arb_evt;
  logic match_evt;

  // Software writes; hardware drops master and transmit on loss
  always_ff @(posedge clk_i)
  begin
    if (init)
      mode_q <= MODE_RST;
    else if (ce_i)
    begin
      if (wr_go && w_lane_q && aw_addr_q == OFS_MODE)
        mode_q <= w_data_q[3:0];
      if (arb_evt)
      begin
        mode_q[MODE_MST] <= 1'b0;
        mode_q[MODE_TX] <= 1'b0;
      end
      // Addressed slave turns to transmit when the read bit is set
      else if (match_evt && eng_i.addr_byte[0])
        mode_q[MODE_TX] <= 1'b1;
    end
  end

  // Own slave address
  always_ff @(posedge clk_i)
  begin
    if (init)
      own_q <= OWN_RST;
    else if (ce_i && wr_go && w_lane_q && aw_addr_q == OFS_OWN)
      own_q <= w_data_q[6:0];
  end

  logic is_mst;
  logic is_tx;
  logic addr_fmt;
  assign is_mst = mode_q[MODE_MST];
  assign is_tx = mode_q[MODE_TX];
  assign addr_fmt = !mode_q[MODE_FS];

  // ****************************************************
  // Event decode
  // ****************************************************
  logic gc_evt;
  logic data_touch;
  logic slv_rx_addr;

  // Address byte is only judged by a slave receiver in addressing format
  assign slv_rx_addr = ce_i && eng_i.addr_valid && !is_mst && !is_tx
                       && addr_fmt;
  assign gc_evt = slv_rx_addr && eng_i.addr_byte == GC_VALUE;
  assign match_evt = slv_rx_addr
                     && (eng_i.addr_byte[7:1] == own_q || gc_evt);
  // data mismatch at clock rise, or own clock still high at clock fall
  assign arb_evt = is_mst && is_tx
                   && ((scl_rise && eng_i.drv_sda != sda_new)
                       || (scl_fall && eng_i.drv_scl));
  // data register access clears the arbitration, address and general call flags
  assign data_touch = ce_i && ((eng_i.data_wr && is_tx)
                               || (eng_i.data_rd && !is_tx));

  // Addressed slave stays live until repeated start, stop or master mode
  logic slv_live_q;
  always_ff @(posedge clk_i)
  begin
    if (init)
      slv_live_q <= 1'b0;
    else if (ce_i)
    begin
      if (start_seen || stop_seen || is_mst)
        slv_live_q <= 1'b0;
      else if (match_evt)
        slv_live_q <= 1'b1;
    end
  end

  logic irq_evt;
  // master transfer end or arbitration loss
  // addressed slave on match and each later transfer end
  // non-addressing slave at every transfer end
  // arbitration loss raises the request with the flag
  assign irq_evt = arb_evt || match_evt
                   || (ce_i && eng_i.xfer_end
                       && (is_mst || !addr_fmt || slv_live_q));

  // ****************************************************
  // Status flags
  // ****************************************************
  logic irq_q;
  logic arb_q;
  logic aas_q;
  logic gc_q;
  logic busy_q;
  logic ack_sw_q;
  logic ack_rx_q;
  logic [3:0] armed_q;
  logic [3:0] clr_ok;

  // A flag may be cleared only if the last status read saw it at 1
  function automatic logic wr0(input logic armed, input logic wbit);
    wr0 = wr_stat && armed && !wbit;
  endfunction

  assign clr_ok[3] = wr0(armed_q[3], w_data_q[BIT_IRQ]);
  assign clr_ok[2] = wr0(armed_q[2], w_data_q[BIT_ARB]);
  assign clr_ok[1] = wr0(armed_q[1], w_data_q[BIT_AAS]);
  assign clr_ok[0] = wr0(armed_q[0], w_data_q[BIT_GC]);

  // Arm on a status read, disarm on a status write; a status read in the same cycle wins
  always_ff @(posedge clk_i)
  begin
    if (init)
      armed_q <= 4'h0;
    else if (ce_i)
    begin
      if (rd_stat)
        armed_q <= {irq_q, arb_q, aas_q, gc_q};
      else if (wr_stat)
        armed_q <= 4'h0;
    end
  end

  // Interrupt request flag; a set in the clear cycle wins
  always_ff @(posedge clk_i)
  begin
    if (init)
      irq_q <= STATUS_RST[BIT_IRQ];
    else if (irq_evt)
      irq_q <= 1'b1;
    else if (clr_ok[3])
      irq_q <= 1'b0;
  end

  // Arbitration lost flag
  always_ff @(posedge clk_i)
  begin
    if (init)
      arb_q <= STATUS_RST[BIT_ARB];
    else if (arb_evt)
      arb_q <= 1'b1;
    else if (clr_ok[2] || data_touch)
      arb_q <= 1'b0;
  end

  // Address recognised flag
  always_ff @(posedge clk_i)
  begin
    if (init)
      aas_q <= STATUS_RST[BIT_AAS];
    else if (match_evt)
      aas_q <= 1'b1;
    else if (clr_ok[1] || data_touch)
      aas_q <= 1'b0;
  end

  // General call flag
  always_ff @(posedge clk_i)
  begin
    if (init)
      gc_q <= STATUS_RST[BIT_GC];
    else if (gc_evt)
      gc_q <= 1'b1;
    else if (clr_ok[0] || data_touch)
      gc_q <= 1'b0;
  end

  // busy follows start and stop seen on the pins
  always_ff @(posedge clk_i)
  begin
    if (init)
      busy_q <= STATUS_RST[BIT_BUSY];
    else if (start_seen)
      busy_q <= 1'b1;
    else if (stop_seen)
      busy_q <= 1'b0;
  end

  // Software acknowledge value, always writable
  always_ff @(posedge clk_i)
  begin
    if (init)
      ack_sw_q <= STATUS_RST[BIT_ACK];
    else if (wr_stat)
      ack_sw_q <= w_data_q[BIT_ACK];
  end

  // capture receiver acknowledge in framed transmit
  always_ff @(posedge clk_i)
  begin
    if (init)
      ack_rx_q <= STATUS_RST[BIT_ACK];
    else if (ce_i && eng_i.ack_valid && is_tx && !mode_q[MODE_SER])
      ack_rx_q <= eng_i.ack_bit;
  end

  // ****************************************************
  // Condition requests and control outputs
  // ****************************************************
  logic start_q;
  logic stop_q;
  logic cond_wr;
  assign cond_wr = wr_stat && is_mst && !w_data_q[BIT_GUARD];

  // One-cycle requests to the shift engine
  always_ff @(posedge clk_i)
  begin
    if (init)
    begin
      start_q <= 1'b0;
      stop_q <= 1'b0;
    end
    else if (ce_i)
    begin
      start_q <= cond_wr && w_data_q[BIT_BUSY];
      stop_q <= cond_wr && !w_data_q[BIT_BUSY];
    end
  end

  // Control bundle; every field, mode bits included, comes straight from flops
  always_comb
  begin
    ctl_o.master = is_mst;
    ctl_o.tx = is_tx;
    ctl_o.fs = mode_q[MODE_FS];
    ctl_o.serial = mode_q[MODE_SER];
    ctl_o.start_req = start_q;
    ctl_o.stop_req = stop_q;
    // receiver drives the software acknowledge value
    ctl_o.ack_drive = ack_sw_q;
    ctl_o.busy = busy_q;
  end

  // ****************************************************
  // Read path
  // ****************************************************
  logic [7:0] status_rd;
  always_comb
  begin
    status_rd = 8'h00;
    status_rd[BIT_BUSY] = busy_q;
    status_rd[BIT_IRQ] = irq_q;
    status_rd[BIT_GUARD] = 1'b1;
    status_rd[BIT_RSVD] = 1'b1;
    status_rd[BIT_ARB] = arb_q;
    status_rd[BIT_AAS] = aas_q;
    status_rd[BIT_GC] = gc_q;
    status_rd[BIT_ACK] = is_tx ? ack_rx_q : ack_sw_q;
  end

  // Read data is registered; reset value shows through status_rd
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (s_axi_araddr)
          OFS_STATUS: s_axi_rdata <= {24'h000000, status_rd};
          OFS_MODE: s_axi_rdata <= {28'h0000000, mode_q};
          OFS_OWN: s_axi_rdata <= {25'h0000000, own_q};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* verif/isf_status_flags_props.sv */
// Port-level checker of the bus status flag block
`default_nettype none
module isf_status_flags_props (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic standby_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire isf_pkg::isf_ctl_t ctl_o,
  input wire logic [isf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  import isf_pkg::*;
  logic [ADDR_W-1:0] rd_addr_q;
  logic st_rd;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Remember which register the pending read targets
  always_ff @(posedge clk_i)
    if (s_axi_arvalid && s_axi_arready)
      rd_addr_q <= s_axi_araddr;
  // Good status read data on the bus
  assign st_rd = s_axi_rvalid && rd_addr_q == OFS_STATUS &&
                 s_axi_rresp == RESP_OKAY;

  // ************
  // Assertions
  // ************
  start_pulse_a:
    assert property (ctl_o.start_req |=> !ctl_o.start_req)
    else $error("start request held too long");
  cond_master_a:
    assert property ((ctl_o.start_req || ctl_o.stop_req) |-> ctl_o.master)
    else $error("condition issued outside master mode");
  cond_excl_a:
    assert property (!(ctl_o.start_req && ctl_o.stop_req))
    else $error("start and stop requested together");
  guard_rsvd_a:
    assert property ($rose(s_axi_rvalid) && st_rd |->
      s_axi_rdata[5:4] == 2'b11 && s_axi_rdata[31:8] == 24'h0)
    else $error("guard or reserved bit not read as one");
  ack_read_a:
    assert property ($rose(s_axi_rvalid) && st_rd && !ctl_o.tx |->
      s_axi_rdata[0] == ctl_o.ack_drive)
    else $error("receive ack bit differs from software value");
  busy_read_a:
    assert property ($rose(s_axi_rvalid) && st_rd |->
      s_axi_rdata[7] == ctl_o.busy)
    else $error("busy bit read differs from bus state");
  busy_set_a:
    assert property ($rose(ctl_o.busy) |->
      !$past(sda_i, 2) && $past(scl_i, 2))
    else $error("busy set without start on the pins");
  busy_clr_a:
    assert property ($fell(ctl_o.busy) && !standby_i && !$past(standby_i)
      |-> $past(sda_i, 2) && $past(scl_i, 2))
    else $error("busy cleared without stop on the pins");
  standby_mode_a:
    assert property (standby_i && ce_i |=> !ctl_o.master && !ctl_o.tx)
    else $error("standby left master or transmit set");
endmodule

bind isf_status_flags isf_status_flags_props isf_status_flags_props_i (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .ce_i(ce_i),
  .standby_i(standby_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .ctl_o(ctl_o),
  .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire

/* verif/isf_bus_peer.sv */
// Behavioural model of another party on the two-wire bus
`default_nettype none
module isf_bus_peer (
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Pull-ups keep both lines high and the clock still between frames
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic start_c;
    #3 sda_o = 1'b0;
    #200 scl_o = 1'b0;
    #50;
  endtask

  // One bit: data moves only while the clock is low
  task automatic bit_c(input logic b);
    #3 sda_o = b;
    #50 scl_o = 1'b1;
    #100 scl_o = 1'b0;
    // Released data returns to the pull-up level, not the last bit
    #10 sda_o = 1'b1;
    #37;
  endtask

  task automatic stop_c;
    #3 sda_o = 1'b0;
    #50 scl_o = 1'b1;
    #50 sda_o = 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire

/* verif/isf_status_flags_tb.sv */
// Self-checking testbench of the bus status flag block
`default_nettype none
module isf_status_flags_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import isf_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic standby_i = 1'b0;
  logic ce = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ab = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [4:0] pl = 5'h0;
  logic ak = 1'b0, dsda = 1'b0, dscl = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  isf_eng_t eng;
  isf_ctl_t ctl;
  wire scl_w;
  wire sda_w;
  int n_fail = 0, n_compared = 0, n_start = 0, n_stop = 0;

  // Engine events are one-hot pulses beside steady drive levels
  assign eng = {pl[0], pl[1], ab, pl[2], ak, pl[3], pl[4], dsda, dscl};
  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  isf_status_flags isf_status_flags_i (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce),
    .standby_i(standby_i),
    .scl_i(scl_w),
    .sda_i(sda_w),
    .eng_i(eng),
    .ctl_o(ctl),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );
  isf_bus_peer isf_bus_peer_i (
    .scl_o(scl_w),
    .sda_o(sda_w)
  );

  // Count condition requests; NBA updates land after this sample
  always @(posedge clk_i)
  begin
    if (ctl.start_req === 1'b1)
      n_start++;
    if (ctl.stop_req === 1'b1)
      n_stop++;
  end

  // ********
  // Tasks
  // ********
  task automatic complete_run;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Ready is looked at before the edge that would take it
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    logic aw, w, ta, tw, tb;
    logic [1:0] r;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge clk_i);
      ta = aw && awready;
      tw = w && wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk_i);
      aw = aw && !ta;
      w = w && !tw;
      awvalid <= aw;
      wvalid <= w;
      bready <= !tb;
    end
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [1:0] er);
    logic ar, ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar = 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge clk_i);
      ta = ar && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk_i);
      ar = ar && !ta;
      arvalid <= ar;
      rready <= !tr;
    end
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rs(input logic [7:0] e);
    rd(OFS_STATUS, e, RESP_OKAY);
  endtask
  task automatic ws(input logic [7:0] d);
    wr(OFS_STATUS, d, RESP_OKAY);
  endtask
  task automatic wm(input logic [7:0] d);
    wr(OFS_MODE, d, RESP_OKAY);
  endtask

  // Pulse 0 transfer end, 1 address, 2 ack, 3 data write, 4 data read
  task automatic ep(input int n, input logic [7:0] b, input logic k);
    @(posedge clk_i);
    ab <= b;
    ak <= k;
    pl <= 5'h1 << n;
    @(posedge clk_i);
    pl <= 5'h0;
  endtask

  // Let a request pulse land, then check both counts
  task automatic cnt(input int s, input int p);
    repeat (3) @(posedge clk_i);
    chk(n_start, s);
    chk(n_stop, p);
  endtask

  // ***********
  // Scenarios
  // ***********
  task automatic t_regs;
    rs(8'h30);
    rd(OFS_MODE, 8'h00, RESP_OKAY);
    rd(OFS_OWN, 8'h00, RESP_OKAY);
    ws(8'hff);
    rs(8'h31);
    ws(8'h00);
    wr(8'h0c, 8'h55, RESP_SLVERR);
    rd(8'h0c, 8'h00, RESP_SLVERR);
    $display("regs done");
  endtask

  task automatic t_slave;
    wr(OFS_OWN, 8'h2a, RESP_OKAY);
    wm(8'h00);
    ep(1, 8'h56, 1'b0);
    ep(0, 8'h00, 1'b0);
    rs(8'h30);
    ep(1, 8'h54, 1'b0);
    rs(8'h74);
    ws(8'h00);
    rs(8'h30);
    ep(1, 8'h00, 1'b0);
    ws(8'h00);
    rs(8'h76);
    ep(4, 8'h00, 1'b0);
    rs(8'h70);
    ws(8'h00);
    rs(8'h30);
    ep(0, 8'h00, 1'b0);
    rs(8'h70);
    ws(8'h00);
    ep(1, 8'h55, 1'b0);
    ep(3, 8'h00, 1'b0);
    rs(8'h70);
    ws(8'h00);
    wm(8'h04);
    chk({31'h0, ctl.fs}, 32'h1);
    ep(0, 8'h00, 1'b0);
    rs(8'h70);
    ws(8'h00);
    $display("slave done");
  endtask

  task automatic t_master;
    wm(8'h01);
    ep(0, 8'h00, 1'b0);
    rs(8'h70);
    ws(8'h20);
    cnt(0, 0);
    ws(8'h80);
    cnt(1, 0);
    ws(8'h80);
    cnt(2, 0);
    ws(8'h00);
    cnt(2, 1);
    wm(8'h00);
    ws(8'h80);
    ws(8'h00);
    cnt(2, 1);
    rs(8'h30);
    $display("master done");
  endtask

  task automatic t_ack;
    wm(8'h02);
    ep(2, 8'h00, 1'b1);
    rs(8'h31);
    wm(8'h0a);
    chk({30'h0, ctl.serial, ctl.tx}, 32'h3);
    ep(2, 8'h00, 1'b0);
    rs(8'h31);
    wm(8'h00);
    ws(8'h01);
    chk({31'h0, ctl.ack_drive}, 32'h1);
    ws(8'h00);
    rs(8'h30);
    wm(8'h02);
    rs(8'h31);
    $display("ack done");
  endtask

  task automatic t_busy;
    wm(8'h00);
    isf_bus_peer_i.start_c();
    rs(8'hb0);
    isf_bus_peer_i.stop_c();
    rs(8'h30);
    $display("busy done");
  endtask

  task automatic t_arb;
    wm(8'h03);
    dsda <= 1'b1;
    isf_bus_peer_i.start_c();
    isf_bus_peer_i.bit_c(1'b0);
    isf_bus_peer_i.stop_c();
    rs(8'h78);
    rd(OFS_MODE, 8'h00, RESP_OKAY);
    ep(4, 8'h00, 1'b0);
    rs(8'h70);
    ws(8'h00);
    wm(8'h03);
    dsda <= 1'b0;
    dscl <= 1'b1;
    isf_bus_peer_i.start_c();
    isf_bus_peer_i.stop_c();
    rs(8'h78);
    ws(8'h00);
    rs(8'h30);
    dscl <= 1'b0;
    $display("arb done");
  endtask

  task automatic t_stby;
    wm(8'h03);
    wr(OFS_OWN, 8'h11, RESP_OKAY);
    @(posedge clk_i);
    standby_i <= 1'b1;
    @(posedge clk_i);
    standby_i <= 1'b0;
    rd(OFS_MODE, 8'h00, RESP_OKAY);
    rd(OFS_OWN, 8'h00, RESP_OKAY);
    rs(8'h30);
    $display("standby done");
  endtask

  // A transfer end while frozen must not raise the request
  task automatic t_ce;
    wm(8'h01);
    ce <= 1'b0;
    ep(0, 8'h00, 1'b0);
    ce <= 1'b1;
    rs(8'h30);
    $display("enable done");
  endtask

  // Main sequence after six reset cycles
  initial
  begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_regs();
    t_slave();
    t_master();
    t_ack();
    t_busy();
    t_arb();
    t_stby();
    t_ce();
    complete_run();
  end

  // Watchdog far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    $display("Error at %0t: timeout", $time);
    complete_run();
  end
endmodule
`default_nettype wire
